// ==== hw/tcc_consts.svh ====
// Constants of the capture/compare timer: register offsets, fields, resets.
// Assumes inclusion by bare name from hw/ design files.
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

`define TCC_OFF_CTRL      8'h00
`define TCC_OFF_COUNT     8'h04
`define TCC_OFF_RELOAD    8'h08
`define TCC_OFF_CAPTURE   8'h0C
`define TCC_OFF_STATUS    8'h10
`define TCC_OFF_IRQ_EN    8'h14
`define TCC_OFF_IRQ_CLR   8'h18
`define TCC_OFF_STATE     8'h1C

`define TCC_CTRL_EN_BIT   0
`define TCC_CTRL_POL_BIT  1
`define TCC_CTRL_PRE_LSB  2
`define TCC_CTRL_PRE_MSB  4

`define TCC_STS_CAP_BIT   0
`define TCC_STS_CMP_BIT   1

`define TCC_COUNT_RESTART 16'h0001
`define TCC_RELOAD_RESET  16'hFFFF
`define TCC_COUNT_RESET   16'h0001

`endif

// ==== hw/tcc_pkg.sv ====
// Types of the capture/compare timer.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package tcc_pkg;
  typedef enum logic [2:0] {
    TCC_IDLE  = 3'b001,
    TCC_ARMED = 3'b010,
    TCC_RUN   = 3'b100
  } tcc_state_t;
endpackage
`default_nettype wire

// ==== hw/tcc_edge_detect.sv ====
// Edge detector for the timer input pin.
// Assumes the pin is synchronous to core_clk.
`default_nettype none
module tcc_edge_detect (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic pin,
  input  wire logic polarity,
  output logic      edge_hit
);
  logic pin_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin;
    end
  end

  // Pin only sampled for edges
  assign edge_hit = polarity ? (pin & ~pin_q) : (~pin & pin_q);
endmodule

// ==== hw/tcc_prescaler.sv ====
// Prescaler giving one tick per 2^pre system clock cycles.
// Assumes clr restarts the division when counting starts.
`default_nettype none
module tcc_prescaler (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       clr,
  input  wire logic [2:0] pre,
  output logic            tick
);
  logic [6:0] div;
  wire  [6:0] div_last = 7'((8'h01 << pre) - 8'h01);

  assign tick = ~clr & (div == div_last);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div <= 7'h00;
    end else if (clr || tick) begin
      div <= 7'h00;
    end else begin
      div <= div + 7'h01;
    end
  end
endmodule

// ==== hw/tcc_timer.sv ====
// Capture/compare timer top with AXI4-Lite register slave and interrupt.
// Assumes timer_in synchronous to core_clk and a single-beat AXI4-Lite master.
`default_nettype none
`include "tcc_consts.svh"
module tcc_timer (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        timer_in,
  output logic             irq,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] d,
                                          input logic [3:0]  be);
    merge16 = {be[1] ? d[15:8] : old_v[15:8], be[0] ? d[7:0] : old_v[7:0]};
  endfunction

  tcc_pkg::tcc_state_t state;
  tcc_pkg::tcc_state_t next_state;
  logic [7:0]  ctrl;
  logic [15:0] count;
  logic [15:0] reload;
  logic [15:0] capture;
  logic [1:0]  status;
  logic [1:0]  irq_en;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  wire en       = ctrl[`TCC_CTRL_EN_BIT];
  wire polarity = ctrl[`TCC_CTRL_POL_BIT];
  wire [2:0] pre = ctrl[`TCC_CTRL_PRE_MSB:`TCC_CTRL_PRE_LSB];
  wire edge_hit;
  wire tick;

  tcc_edge_detect u_edge (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pin      (timer_in),
    .polarity (polarity),
    .edge_hit (edge_hit)
  );

  tcc_prescaler u_pre (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clr      (state != tcc_pkg::TCC_RUN),
    .pre      (pre),
    .tick     (tick)
  );

  // Write channel: address and data accepted in either order
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  wire aw_fire = s_axi_awvalid & s_axi_awready;
  wire w_fire  = s_axi_wvalid & s_axi_wready;
  wire have_aw = aw_held | aw_fire;
  wire have_w  = w_held | w_fire;
  wire wr_go   = have_aw & have_w;
  wire [7:0]  wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire [3:0]  wr_strb = w_held ? w_strb : s_axi_wstrb;
  wire wr_ctrl   = wr_go & (wr_addr == `TCC_OFF_CTRL);
  wire wr_count  = wr_go & (wr_addr == `TCC_OFF_COUNT);
  wire wr_reload = wr_go & (wr_addr == `TCC_OFF_RELOAD);
  wire wr_irq_en = wr_go & (wr_addr == `TCC_OFF_IRQ_EN);
  wire wr_clr    = wr_go & (wr_addr == `TCC_OFF_IRQ_CLR);
  wire wr_known  = wr_ctrl | wr_count | wr_reload | wr_irq_en | wr_clr;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      aw_held <= have_aw & ~wr_go;
      w_held  <= have_w & ~wr_go;
      if (aw_fire) aw_addr <= s_axi_awaddr;
      if (w_fire) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_known ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Timer core
  wire running   = state == tcc_pkg::TCC_RUN;
  wire cap_event = running & edge_hit;
  wire cmp_event = running & tick & (count == reload);
  wire cmp_only  = cmp_event & ~cap_event;
  wire start_hit = (state == tcc_pkg::TCC_ARMED) & edge_hit;

  always_comb begin
    next_state = state;
    case (state)
      tcc_pkg::TCC_IDLE:  if (en) next_state = tcc_pkg::TCC_ARMED;
      tcc_pkg::TCC_ARMED: if (!en) next_state = tcc_pkg::TCC_IDLE;
                          else if (edge_hit) next_state = tcc_pkg::TCC_RUN;
      tcc_pkg::TCC_RUN:   if (!en) next_state = tcc_pkg::TCC_IDLE;
      default:            next_state = tcc_pkg::TCC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state  <= tcc_pkg::TCC_IDLE;
      ctrl   <= 8'h00;
      reload <= `TCC_RELOAD_RESET;
      irq_en <= 2'h0;
    end else begin
      state <= next_state;
      if (wr_ctrl) ctrl <= wr_strb[0] ? wr_data[7:0] : ctrl;
      if (wr_reload) reload <= merge16(reload, wr_data, wr_strb);
      if (wr_irq_en && wr_strb[0]) irq_en <= wr_data[1:0];
    end
  end

  // Hardware restarts win over a software count write in the same cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= `TCC_COUNT_RESET;
    end else if (cap_event || cmp_only) begin
      count <= `TCC_COUNT_RESTART;
    end else if (running && tick) begin
      count <= count + 16'h0001;
    end else if (wr_count) begin
      count <= merge16(count, wr_data, wr_strb);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      capture <= 16'h0000;
    end else if (cap_event) begin
      capture <= count;
    end
  end

  // Sticky status: set beats clear
  wire [1:0] set_bits = {cmp_only, cap_event};
  wire [1:0] clr_bits = (wr_clr && wr_strb[0]) ? wr_data[1:0] : 2'h0;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= 2'h0;
    end else begin
      status <= (status & ~clr_bits) | set_bits;
    end
  end

  assign irq = |(status & irq_en);

  // Read channel
  wire [7:0] rd_addr = s_axi_araddr;
  wire rd_hit = (rd_addr == `TCC_OFF_CTRL) | (rd_addr == `TCC_OFF_COUNT) |
                (rd_addr == `TCC_OFF_RELOAD) | (rd_addr == `TCC_OFF_CAPTURE) |
                (rd_addr == `TCC_OFF_STATUS) | (rd_addr == `TCC_OFF_IRQ_EN) |
                (rd_addr == `TCC_OFF_IRQ_CLR) | (rd_addr == `TCC_OFF_STATE);
  wire [31:0] rd_val =
      (rd_addr == `TCC_OFF_CTRL)    ? {24'h000000, ctrl} :
      (rd_addr == `TCC_OFF_COUNT)   ? {16'h0000, count} :
      (rd_addr == `TCC_OFF_RELOAD)  ? {16'h0000, reload} :
      (rd_addr == `TCC_OFF_CAPTURE) ? {16'h0000, capture} :
      (rd_addr == `TCC_OFF_STATUS)  ? {30'h00000000, status} :
      (rd_addr == `TCC_OFF_IRQ_EN)  ? {30'h00000000, irq_en} :
      (rd_addr == `TCC_OFF_STATE)   ? {29'h00000000, state} : 32'h0000_0000;

  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Assertions: timer core
  AST_START_NO_IRQ: assert property (@(posedge core_clk) disable iff (!rst_n)
    start_hit |=> status == ($past(status) & ~$past(clr_bits)))
    else $error("Start edge changed status");
  AST_HOLD_ARMED: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == tcc_pkg::TCC_ARMED) && !wr_count |=> count == $past(count))
    else $error("Count moved before start edge");
  AST_IDLE_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == tcc_pkg::TCC_IDLE) && !wr_count |=> count == $past(count))
    else $error("Count moved while disabled");
  AST_NO_FLAG_STOPPED: assert property (@(posedge core_clk) disable iff (!rst_n)
    !running |-> set_bits == 2'h0)
    else $error("Flag raised while not counting");
  AST_START_RUN: assert property (@(posedge core_clk) disable iff (!rst_n)
    start_hit && en |=> running)
    else $error("Start edge did not start counting");
  AST_DISABLE_STOP: assert property (@(posedge core_clk) disable iff (!rst_n)
    !en && state != tcc_pkg::TCC_IDLE |=> state == tcc_pkg::TCC_IDLE)
    else $error("Disable did not stop timer");
  AST_STATE_ONEHOT: assert property (@(posedge core_clk) disable iff (!rst_n)
    $onehot(state))
    else $error("State not one-hot");
  AST_POLARITY: assert property (@(posedge core_clk) disable iff (!rst_n)
    edge_hit |-> (timer_in == polarity))
    else $error("Edge of wrong polarity");
  AST_NO_TICK_STOPPED: assert property (@(posedge core_clk) disable iff (!rst_n)
    !running |-> !tick)
    else $error("Tick while not counting");
  AST_CAPTURE: assert property (@(posedge core_clk) disable iff (!rst_n)
    cap_event |=> capture == $past(count))
    else $error("Capture value wrong");
  AST_CAPTURE_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
    !cap_event |=> $stable(capture))
    else $error("Capture changed without edge");
  AST_CAP_RESTART: assert property (@(posedge core_clk) disable iff (!rst_n)
    cap_event |=> count == 16'h0001 && status[`TCC_STS_CAP_BIT])
    else $error("Capture did not restart count");
  AST_IRQ_CAPTURE: assert property (@(posedge core_clk) disable iff (!rst_n)
    cap_event && irq_en[0] && !wr_irq_en |=> irq)
    else $error("Capture raised no interrupt");
  AST_NO_SKIP: assert property (@(posedge core_clk) disable iff (!rst_n)
    running && tick && count != reload && !cap_event |=> count == $past(count) + 16'h0001)
    else $error("Count did not step");
  AST_RELOAD_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
    !wr_reload |=> $stable(reload))
    else $error("Compare value changed without write");
  AST_CMP_RESTART: assert property (@(posedge core_clk) disable iff (!rst_n)
    cmp_only |=> count == 16'h0001 && status[`TCC_STS_CMP_BIT])
    else $error("Compare did not restart count");
  AST_IRQ_COMPARE: assert property (@(posedge core_clk) disable iff (!rst_n)
    cmp_only && irq_en[1] && !wr_irq_en |=> irq)
    else $error("Compare raised no interrupt");
  AST_TICK_RATE: assert property (@(posedge core_clk) disable iff (!rst_n)
    tick && pre == 3'h1 && running ##1 running && $stable(pre) |-> !tick)
    else $error("Prescale ticked too soon");
  AST_TICK_EVERY: assert property (@(posedge core_clk) disable iff (!rst_n)
    tick && pre == 3'h0 ##1 running && pre == 3'h0 |-> tick)
    else $error("Undivided clock missed a tick");
  AST_COUNT_WAITS: assert property (@(posedge core_clk) disable iff (!rst_n)
    running && !tick && !cap_event && !wr_count |=> $stable(count))
    else $error("Count moved between ticks");
  AST_BOTH_CAPTURE: assert property (@(posedge core_clk) disable iff (!rst_n)
    cap_event && cmp_event |=> !status[`TCC_STS_CMP_BIT] || $past(status[1]))
    else $error("Coincident events both flagged");

  // Assertions: register bus handshake
  AST_BVALID_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped early");
  AST_RVALID_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("Read response dropped early");
  AST_WR_ANSWER: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_go |=> s_axi_bvalid)
    else $error("Write not answered");
  AST_RD_ANSWER: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read not answered");
  AST_BUSY_REFUSE: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("Write taken during response");
  AST_AW_HELD_REFUSE: assert property (@(posedge core_clk) disable iff (!rst_n)
    aw_held |-> !s_axi_awready)
    else $error("Second address taken");
  AST_CTRL_OKAY: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_ctrl |=> s_axi_bvalid && s_axi_bresp == 2'h0)
    else $error("Control write not okay");
  AST_BRESP_UNMAPPED: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_go && !wr_known |=> s_axi_bresp == 2'h2)
    else $error("Unmapped write not refused");
endmodule
`default_nettype wire

// ==== dv/tcc_pin_src.sv ====
// Signal source model on the timer input pin.
// Assumes a core_clk-synchronous pin; LAG is the fixed cable delay in cycles.
`default_nettype none
module tcc_pin_src #(
  parameter int LAG = 2
) (
  input  wire logic core_clk,
  input  wire logic level_req,
  output logic      timer_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [LAG-1:0] pipe = '0;
  // Fixed lag, so edge spacing at the pin equals the requested spacing
  always_ff @(posedge core_clk) begin
    pipe <= {pipe[LAG-2:0], level_req};
  end
  assign timer_in = pipe[LAG-1];
endmodule
`default_nettype wire

// ==== dv/timer_capture_compare_mode_bench.sv ====
// Self-checking bench of the capture/compare timer.
// Assumes tcc_timer as AXI4-Lite slave and tcc_pin_src on timer_in.
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %s expected %0h seen %0h", n, e, g); end end
module timer_capture_compare_mode_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = '0, rst_n = '0, level_req = '0;
  logic        timer_in, irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic        s_axi_arvalid = '0, s_axi_rready = '0;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb = '0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  int          fails = 0, samples_checked = 0, cyc = 0;
  logic [7:0]  ra [6] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h1C};
  logic [31:0] rx [6] = '{32'h0, 32'h1, 32'hFFFF, 32'h0, 32'h0, 32'h1};

  tcc_timer u_tcc_timer (.core_clk, .rst_n, .timer_in, .irq, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  tcc_pin_src u_tcc_pin_src (.core_clk, .level_req, .timer_in);

  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  // Pin rests at the active level, so the first change after enable is the wrong edge
  task automatic arm(input logic pol, input logic [2:0] pre, input logic [15:0] rl,
                     input logic [1:0] ien);
    @(posedge core_clk);
    level_req <= pol;
    wr(8'h00, {27'h0, pre, pol, 1'h0});
    wr(8'h04, 32'h1);
    wr(8'h08, {16'h0, rl});
    wr(8'h14, {30'h0, ien});
    wr(8'h18, 32'h3);
    wr(8'h00, {27'h0, pre, pol, 1'h1});
    rd(8'h1C);
    `CHK("state armed", 32'h2, rv)
  endtask

  // Capture after d cycles at prescale 2^p; first one measured from the start edge
  function automatic int cap_lo(int d, int p, int j);
    return (d >> p) - (j == 1);
  endfunction

  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #100000;
    fails++;
    results();
  end

  initial begin
    int d, t0;
    logic [2:0] p;
    logic pol;
    d = $urandom(94530);
    repeat (20) @(posedge core_clk);
    rst_n <= 1'h1;
    foreach (ra[i]) begin
      rd(ra[i]);
      `CHK("reset value", rx[i], rv)
    end
    rd(8'h40);
    `CHK("unmapped rresp", 2'h2, rs)
    wr(8'h40, 32'h5);
    `CHK("unmapped bresp", 2'h2, rs)
    for (int i = 0; i < 4; i++) begin
      pol = i[0];
      p = 3'(i);
      d = 8 * (4 + $urandom % 16);
      arm(pol, p, 16'hFFFF, 2'h1);
      @(posedge core_clk);
      level_req <= ~pol;
      repeat (6) @(posedge core_clk);
      rd(8'h1C);
      `CHK("state wrong edge", 32'h2, rv)
      rd(8'h04);
      `CHK("count held", 32'h1, rv)
      @(posedge core_clk);
      level_req <= pol;
      t0 = cyc;
      repeat (6) @(posedge core_clk);
      rd(8'h1C);
      `CHK("state run", 32'h4, rv)
      `CHK("irq start", 1'h0, irq)
      for (int j = 1; j < 3; j++) begin
        @(posedge core_clk);
        level_req <= ~pol;
        while (cyc < t0 + j * d) @(posedge core_clk);
        level_req <= pol;
        repeat (6) @(posedge core_clk);
        rd(8'h0C);
        `CHK("capture", 1'h1, rv >= cap_lo(d, p, j) && rv <= (d >> p) + (p != 0 || j == 1))
        rd(8'h10);
        `CHK("status capture", 2'h1, rv[1:0])
        `CHK("irq capture", 1'h1, irq)
        wr(8'h18, 32'h1);
        `CHK("irq cleared", 1'h0, irq)
      end
    end
    d = 16 + $urandom % 16;
    arm(1'h1, 3'h0, 16'(d), 2'h0);
    @(posedge core_clk);
    level_req <= 1'h0;
    @(posedge core_clk);
    level_req <= 1'h1;
    t0 = cyc;
    // Capture edge lands on the very tick at which the count meets the compare value
    @(posedge core_clk);
    level_req <= 1'h0;
    while (cyc < t0 + d) @(posedge core_clk);
    level_req <= 1'h1;
    repeat (6) @(posedge core_clk);
    rd(8'h10);
    `CHK("status coincide", 2'h1, rv[1:0])
    rd(8'h0C);
    `CHK("capture coincide", d, rv)
    wr(8'h18, 32'h1);
    repeat (3 * d) @(posedge core_clk);
    rd(8'h10);
    `CHK("status compare", 2'h2, rv[1:0])
    `CHK("irq masked", 1'h0, irq)
    repeat (8) begin
      rd(8'h04);
      `CHK("count bound", 1'h1, rv >= 1 && rv <= d)
    end
    wr(8'h14, 32'h2);
    `CHK("irq compare", 1'h1, irq)
    wr(8'h08, 32'hFFFF);
    wr(8'h18, 32'h2);
    rd(8'h10);
    `CHK("status cleared", 32'h0, rv)
    results();
  end
endmodule
`default_nettype wire
